// ### common/port1_pkg.sv
// Constants, register map and carrier types for the port 1 pin controller.
// Assumes a plain one-cycle register port with read data one cycle later.
// Summary of operation
// - Select bit 7 gives pin 7 to interrupt 3/timer V
// - Select bit 6 gives pin 6 to interrupt 2
// - Select bit 5 gives pin 5 to interrupt 1/timer B1
// - Select bit 4 gives pin 4 to interrupt 0
// - Select bit 3 routes second serial transmit out
// - Select bit 2 makes pin 1 the PWM output
// - Select bit 1 routes serial transmit out
// - Select bit 0 makes pin 0 clock output
// - Direction 1 drives pin, 0 makes input
// - Stored data bit is the pin output level
// - Output pins read back stored data
// - Input pins read back the two-flop synchronised pin level
// - Reserved bit 3 of data and pull-up reads 1
// - Pull-up acts only on input pins
// - Pull-up on when enable is 1
// - Reset makes every pin an input, bits clear
// - Direction bits are write only, per pin
// - Pin alternate functions override the direction bit for drive, not for readback
package port1_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] FUNC_SEL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] DIR_OFS      = 4'h4;
    localparam logic [ADDR_W-1:0] DATA_OFS     = 4'h8;
    localparam logic [ADDR_W-1:0] PULLUP_OFS   = 4'hc;

    localparam logic [DATA_W-1:0] FUNC_SEL_RST = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST      = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST     = 8'h00;
    localparam logic [DATA_W-1:0] PULLUP_RST   = 8'h00;

    // Pins that exist; bit 3 is reserved
    localparam logic [DATA_W-1:0] PIN_MASK     = 8'hf7;
    localparam logic [DATA_W-1:0] RSVD_ONES    = 8'h08;
    localparam logic [DATA_W-1:0] UNMAPPED_RD  = 8'h00;

    localparam int unsigned SEL_RTC  = 0;
    localparam int unsigned SEL_TX   = 1;
    localparam int unsigned SEL_PWM  = 2;
    localparam int unsigned SEL_TX2  = 3;
    localparam int unsigned SEL_INT0 = 4;
    localparam int unsigned SEL_INT1 = 5;
    localparam int unsigned SEL_INT2 = 6;
    localparam int unsigned SEL_INT3 = 7;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_type;

    typedef struct packed {
        logic ext_int3_in;
        logic ext_int2_in;
        logic ext_int1_in;
        logic ext_int0_in;
        logic timer_v_trigger_in;
        logic timer_b1_event_in;
    } func_in_type;

endpackage

// ### design/port1_gpio.sv
// Port 1 pin controller: function select, direction, data and pull-up registers.
// Assumes pins are asynchronous inputs and the pad resolves drive from the enables.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
module port1_gpio
    import port1_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              sys_rst_i,
    input  wire reg_req_type       req_i,
    output logic [DATA_W-1:0]      rdata_o,
    input  wire logic [DATA_W-1:0] pin_i,
    output logic [DATA_W-1:0]      pin_o,
    output logic [DATA_W-1:0]      pin_oe_n_o,
    output logic [DATA_W-1:0]      pullup_on_o,
    input  wire logic              pwm_i,
    input  wire logic              rtc_clock_i,
    output func_in_type            func_o,
    output logic                   serial2_tx_select_o,
    output logic                   serial_tx_select_o
);

    logic [DATA_W-1:0] func_sel_q;
    logic [DATA_W-1:0] dir_q;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] pullup_q;
    logic [DATA_W-1:0] sync1_q;
    logic [DATA_W-1:0] sync2_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] alt_out_en;
    logic [DATA_W-1:0] alt_in_en;
    logic [DATA_W-1:0] alt_level;
    logic [DATA_W-1:0] gpio_drive;

    function automatic logic hit(input reg_req_type r, input logic [ADDR_W-1:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            func_sel_q <= FUNC_SEL_RST;
        end else if (hit(req_i, FUNC_SEL_OFS)) begin
            func_sel_q <= req_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dir_q <= DIR_RST;
        end else if (hit(req_i, DIR_OFS)) begin
            dir_q <= req_i.wdata & PIN_MASK;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_q <= DATA_RST;
        end else if (hit(req_i, DATA_OFS)) begin
            data_q <= req_i.wdata & PIN_MASK;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pullup_q <= PULLUP_RST;
        end else if (hit(req_i, PULLUP_OFS)) begin
            pullup_q <= req_i.wdata & PIN_MASK;
        end
    end

    // Two-flop synchroniser on pad levels
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    // Pin ownership by alternate function
    always_comb begin
        alt_out_en = '0;
        alt_in_en  = '0;
        alt_level  = '0;
        alt_in_en[7]  = func_sel_q[SEL_INT3];
        alt_in_en[6]  = func_sel_q[SEL_INT2];
        alt_in_en[5]  = func_sel_q[SEL_INT1];
        alt_in_en[4]  = func_sel_q[SEL_INT0];
        alt_out_en[1] = func_sel_q[SEL_PWM];
        alt_level[1]  = pwm_i;
        alt_out_en[0] = func_sel_q[SEL_RTC];
        alt_level[0]  = rtc_clock_i;
    end

    assign gpio_drive = dir_q & ~(alt_out_en | alt_in_en) & PIN_MASK;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_o       <= '0;
            pin_oe_n_o  <= '1;
            pullup_on_o <= '0;
        end else begin
            pin_o       <= (alt_out_en & alt_level) | (~alt_out_en & data_q);
            pin_oe_n_o  <= ~(gpio_drive | alt_out_en);
            pullup_on_o <= pullup_q & ~gpio_drive & ~alt_out_en & PIN_MASK;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            func_o              <= '0;
            serial2_tx_select_o <= 1'b0;
            serial_tx_select_o  <= 1'b0;
        end else begin
            func_o.ext_int3_in        <= func_sel_q[SEL_INT3] & sync2_q[7];
            func_o.timer_v_trigger_in <= func_sel_q[SEL_INT3] & sync2_q[7];
            func_o.ext_int2_in        <= func_sel_q[SEL_INT2] & sync2_q[6];
            func_o.ext_int1_in        <= func_sel_q[SEL_INT1] & sync2_q[5];
            func_o.timer_b1_event_in  <= func_sel_q[SEL_INT1] & sync2_q[5];
            func_o.ext_int0_in        <= func_sel_q[SEL_INT0] & sync2_q[4];
            serial2_tx_select_o       <= func_sel_q[SEL_TX2];
            serial_tx_select_o        <= func_sel_q[SEL_TX];
        end
    end

    always_comb begin
        rdata_d = UNMAPPED_RD;
        if (req_i.rd) begin
            unique case (req_i.addr)
                FUNC_SEL_OFS: rdata_d = func_sel_q;
                DATA_OFS:     rdata_d = (((dir_q & data_q) | (~dir_q & sync2_q)) & PIN_MASK) | RSVD_ONES;
                PULLUP_OFS:   rdata_d = pullup_q | RSVD_ONES;
                default:      rdata_d = UNMAPPED_RD; // direction reads as zero
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rdata_d;
        end
    end

endmodule

// ### tb/port1_gpio_assertions.sv
// Concurrent checks on the port 1 pin controller.
// Bound to port1_gpio and sees only its ports.
`timescale 1ns/100ps
module port1_gpio_checker
    import port1_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              sys_rst_i,
    input  wire reg_req_type       req_i,
    input  wire logic [DATA_W-1:0] rdata_o,
    input  wire logic [DATA_W-1:0] pin_o,
    input  wire logic [DATA_W-1:0] pin_oe_n_o,
    input  wire logic [DATA_W-1:0] pullup_on_o,
    input  wire func_in_type       func_o,
    input  wire logic              serial_tx_select_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_DIR_WO: assert property (req_i.rd && req_i.addr == DIR_OFS |=> rdata_o == 8'h00)
        else $error("direction read not zero");
    AST_RSVD_ONE: assert property (req_i.rd && req_i.addr == DATA_OFS |=> rdata_o[3])
        else $error("reserved data bit not one");
    AST_PU_INPUT: assert property ((pullup_on_o & ~pin_oe_n_o) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_INT0_IN: assert property (func_o.ext_int0_in |-> pin_oe_n_o[4])
        else $error("interrupt 0 pin driven");
    AST_INT2_IN: assert property (func_o.ext_int2_in |-> pin_oe_n_o[6])
        else $error("interrupt 2 pin driven");
    AST_DIR_PIN2: assert property (req_i.wr && req_i.addr == DIR_OFS |-> ##2 pin_oe_n_o[2] == !$past(req_i.wdata[2], 2))
        else $error("pin 2 enable wrong");
    AST_DATA_PIN2: assert property (req_i.wr && req_i.addr == DATA_OFS |-> ##2 pin_o[2] == $past(req_i.wdata[2], 2))
        else $error("pin 2 level wrong");
    AST_RST_INPUT: assert property ($fell(sys_rst_i) |-> pin_oe_n_o == 8'hff && pullup_on_o == 8'h00)
        else $error("pins not inputs after reset");
    AST_TX_SEL: assert property (req_i.wr && req_i.addr == FUNC_SEL_OFS |-> ##2 serial_tx_select_o == $past(req_i.wdata[1], 2))
        else $error("serial select wrong");
endmodule
bind port1_gpio port1_gpio_checker chk_i (.core_clk_i, .sys_rst_i, .req_i, .rdata_o, .pin_o, .pin_oe_n_o,
    .pullup_on_o, .func_o, .serial_tx_select_o);

// ### tb/pin_model.sv
// Pad model: each pin shows the drive, else the pull-up, else the outside level.
// Assumes active-low enables and a weak outside source.
`timescale 1ns/100ps
module pin_model (
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_n_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] level_o
);
    assign level_o = (~oe_n_i & drv_i) | (oe_n_i & (pu_i | ext_i));
endmodule

// ### tb/tb_top.sv
// Self-checking bench for port1_gpio with a pad model on its pins.
// Assumes the register map and timing of the port 1 package.
`timescale 1ns/100ps
module tb_top;
    import port1_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    reg_req_type req_i = '0;
    logic [7:0]  rdata_o, pin_o, pin_oe_n_o, pullup_on_o, pin_i, rv;
    logic [7:0]  ext = 8'h00;
    logic        pwm_i = 1'b1;
    logic        rtc_clock_i = 1'b1;
    logic        s2, s1;
    func_in_type func_o;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // Direction, data, pull-up, outside level, data read, enables, pull-ups on, pull-up read
    logic [63:0] rows [4] = '{64'hffa50000ad080008, 64'h00ff003c3cff0008,
                              64'h0f5aff00faf8f0ff, 64'hf00f0fa00f0f070f};
    // Pin levels, enables, then function outputs with both serial selects
    logic [23:0] sel_exp [8] = '{24'h010800, 24'h000801, 24'h020800, 24'h000802,
                                 24'h001810, 24'h002824, 24'h004840, 24'h008888};
    port1_gpio dut (.core_clk_i, .sys_rst_i, .req_i, .rdata_o, .pin_i, .pin_o, .pin_oe_n_o, .pullup_on_o,
        .pwm_i, .rtc_clock_i, .func_o, .serial2_tx_select_o(s2), .serial_tx_select_o(s1));
    pin_model pad (.drv_i(pin_o), .oe_n_i(pin_oe_n_o), .pu_i(pullup_on_o), .ext_i(ext), .level_o(pin_i));
    always #4 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
        @(posedge core_clk_i);
        req_i <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk_i);
        req_i <= '0;
        #1 rv = rdata_o;
    endtask
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        bus(DIR_OFS, 8'h00, 1'b0);
        chk("dir_rd", rv, 8'h00);
        bus(4'h2, 8'h00, 1'b0);
        chk("unmapped", rv, 8'h00);
        foreach (rows[i]) begin
            bus(DIR_OFS, rows[i][63:56], 1'b1);
            bus(DATA_OFS, rows[i][55:48], 1'b1);
            bus(PULLUP_OFS, rows[i][47:40], 1'b1);
            ext = rows[i][39:32];
            repeat (4) @(posedge core_clk_i);
            bus(DATA_OFS, 8'h00, 1'b0);
            chk("data_rd", rv, rows[i][31:24]);
            bus(PULLUP_OFS, 8'h00, 1'b0);
            chk("pu_rd", rv, rows[i][7:0]);
            chk("oe_n", pin_oe_n_o, rows[i][23:16]);
            chk("pu_on", pullup_on_o, rows[i][15:8]);
        end
        bus(DIR_OFS, 8'hff, 1'b1);
        bus(DATA_OFS, 8'h00, 1'b1);
        bus(PULLUP_OFS, 8'h00, 1'b1);
        ext = 8'hff;
        for (int i = 0; i < 8; i++) begin
            bus(FUNC_SEL_OFS, 8'h01 << i, 1'b1);
            repeat (4) @(posedge core_clk_i);
            #1 chk("sel", {pin_o, pin_oe_n_o, func_o, s2, s1}, sel_exp[i]);
            bus(FUNC_SEL_OFS, 8'h00, 1'b0);
            chk("sel_rd", rv, 8'h01 << i);
        end
        sys_rst_i <= 1'b1;
        @(posedge core_clk_i);
        #1 chk("rst", {pin_oe_n_o, pullup_on_o, pin_o}, 24'hff0000);
        sys_rst_i <= 1'b0;
        bus(FUNC_SEL_OFS, 8'h00, 1'b0);
        chk("rst_sel", rv, 8'h00);
        wrap_up();
    end
endmodule
